/* File: logic/cid_pkg.sv */
// package: register map, field positions and status types of the caller-id front end
`default_nettype none
package cid_pkg;
  localparam logic [7:0] tone_decode_status_ofs = 8'h00;
  localparam logic [7:0] decoder_power_select_ofs = 8'h04;
  localparam logic [7:0] power_clock_fsk_status_ofs = 8'h08;
  localparam logic [7:0] irq_status_ofs = 8'h0c;
  localparam logic [7:0] irq_clear_ofs = 8'h10;
  localparam logic [7:0] irq_enable_ofs = 8'h14;
  localparam int code_lsb = 0;
  localparam int steer_bit = 6;
  localparam int cmp_bit = 7;
  localparam int sel_lo_bit = 6;
  localparam int sel_hi_bit = 7;
  localparam int cd_bit = 1;
  localparam int fsk_bit = 2;
  localparam int irq_tone_bit = 0;
  localparam int irq_fsk_bit = 1;
  localparam logic [1:0] pwr_off = 2'h0;
  localparam logic [1:0] pwr_fsk = 2'h1;
  localparam logic [1:0] pwr_tone = 2'h2;
  localparam logic [1:0] pwr_bad = 2'h3;
  localparam logic [7:0] power_select_reset = 8'h00;
  localparam logic [7:0] pcfs_reset = 8'h00;
  localparam logic [1:0] irq_reset = 2'h0;
  localparam logic [3:0] key_d_code = 4'h0;
  localparam logic [3:0] key_0_code = 4'ha;
  localparam logic [3:0] key_star_code = 4'hb;
  localparam logic [3:0] key_hash_code = 4'hc;
  localparam int sync_stages = 2;
  typedef struct packed {
    logic [3:0] tone_code;
    logic tone_valid_steer;
    logic receiver_output_enable;
    logic fsk_raw;
    logic carrier_absent;
    logic comparator_result;
  } front_s;
  typedef enum logic [1:0] {
    ph_idle = 2'b01,
    ph_data = 2'b10
  } bus_phase_e;
endpackage
`default_nettype wire

/* File: logic/level_sync.sv */
// two-flop synchroniser for a bundle of levels
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int width = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [width-1:0] d,
  input wire logic [width-1:0] rst_val,
  output logic [width-1:0] q
);
  logic [width-1:0] meta;
  logic [width-1:0] stage;

  initial begin
    if (width < 1) begin
      $error("level_sync width must be positive");
    end
  end

  // first stage feeds only the second; both stages reset to zero, rst_val is not used
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= '0;
      stage <= '0;
    end else begin
      meta <= d;
      stage <= meta;
    end
  end

  assign q = stage;
endmodule // level_sync
`default_nettype wire

/* File: logic/caller_id_decoder_status_control.sv */
// caller-id tone/fsk receiver status and control registers on ahb-lite
// Overview of operation
// - tone code 1-9 binary, 0=1010, *=1011, #=1100, A-C=1101..1111, D=0000.
// - tone code holds last accepted pair until next pair registers.
// - bit 6 steering flag high after register update, low when steering drops.
// - registered tone pair raises interrupt when its enable is set.
// - power select bits 7:6: 00 off, 01 fsk, 10 tone, 11 invalid.
// - tone receiver powered reroutes port 6 bits 0,1 to steering pins.
// - fsk bit reads 1 for mark, 0 for space, raw data.
// - carrier flag bit 1 reads 0 when carrier valid, 1 otherwise.
// - without carrier fsk bit held at 1, data blocked.
// - falling edge of fsk bit can raise an interrupt.
// - bit 7 shows comparator result, 1 when input above reference.
`timescale 1ns/1ps
`default_nettype none
module caller_id_decoder_status_control (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire cid_pkg::front_s front_in,
  output logic tone_rx_power,
  output logic fsk_power,
  output logic port6_reroute,
  output logic irq
);
  import cid_pkg::*;

  front_s fsync;
  logic [3:0] tone_code;
  logic steer_d;
  logic fsk_d;
  logic [7:0] power_sel;
  logic [7:0] pcfs;
  logic [1:0] irq_status;
  logic [1:0] irq_enable;
  logic ap_valid;
  logic ap_write;
  logic [7:0] ap_addr;
  logic wr_fire;
  logic fsk_bit_out;
  logic tone_event;
  logic fsk_event;
  logic [1:0] clear_bits;
  logic [7:0] status_byte;
  logic [31:0] next_rdata;
  logic [1:0] warm;
  logic warm_done;
  logic rd_take;

  // front-end status is asynchronous to the cpu clock
  level_sync #(.width($bits(front_s))) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(front_in),
    .rst_val('0),
    .q(fsync)
  );

  // ---------------- ahb-lite slave ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= 8'h00;
    end else if (hready) begin
      ap_valid <= hsel && htrans[1];
      ap_write <= hwrite;
      ap_addr <= haddr;
    end
  end

  // zero wait states, always okay; unmapped reads as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign wr_fire = ap_valid && ap_write;
  assign rd_take = hready && hsel && htrans[1] && !hwrite;

  // sync stages hold reset zeros for two edges, which would fake an fsk
  // fall; edges stay masked until stages and edge flops see real levels
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      warm <= 2'h0;
    end else if (warm != 2'h3) begin
      warm <= warm + 2'h1;
    end
  end

  assign warm_done = warm == 2'h3;

  // ---------------- tone receiver and fsk edge ----------------
  assign fsk_bit_out = fsync.carrier_absent ? 1'b1 : fsync.fsk_raw;
  assign tone_event = warm_done && fsync.tone_valid_steer && !steer_d;

  // code latched only on a new registered pair
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tone_code <= key_d_code;
    end else if (tone_event && fsync.receiver_output_enable) begin
      tone_code <= fsync.tone_code;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      steer_d <= 1'b0;
      fsk_d <= 1'b1;
    end else begin
      steer_d <= fsync.tone_valid_steer;
      fsk_d <= fsk_bit_out;
    end
  end

  assign fsk_event = warm_done && fsk_d && !fsk_bit_out;

  // ---------------- control registers ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_sel <= power_select_reset;
    end else if (wr_fire && ap_addr == decoder_power_select_ofs) begin
      // only the select pair is kept; the other bits are not ours
      power_sel <= {hwdata[sel_hi_bit], hwdata[sel_lo_bit], 6'h00};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pcfs <= pcfs_reset;
    end else begin
      pcfs <= {5'h00, fsk_bit_out, fsync.carrier_absent, 1'b0};
    end
  end

  // 11 is invalid: neither front end is powered, matching failure
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tone_rx_power <= 1'b0;
      fsk_power <= 1'b0;
      port6_reroute <= 1'b0;
    end else begin
      tone_rx_power <= power_sel[7:6] == pwr_tone;
      fsk_power <= power_sel[7:6] == pwr_fsk;
      port6_reroute <= power_sel[7:6] == pwr_tone;
    end
  end

  // ---------------- interrupts ----------------
  assign clear_bits = (wr_fire && ap_addr == irq_clear_ofs) ?
                      hwdata[1:0] : 2'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_enable <= irq_reset;
    end else if (wr_fire && ap_addr == irq_enable_ofs) begin
      irq_enable <= hwdata[1:0];
    end
  end

  // set wins over a same-cycle clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= irq_reset;
    end else begin
      irq_status[irq_tone_bit] <= tone_event ||
        (irq_status[irq_tone_bit] && !clear_bits[irq_tone_bit]);
      irq_status[irq_fsk_bit] <= fsk_event ||
        (irq_status[irq_fsk_bit] && !clear_bits[irq_fsk_bit]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end

  // ---------------- read path ----------------
  always_comb begin
    status_byte = 8'h00;
    status_byte[3:0] = tone_code;
    status_byte[steer_bit] = steer_d;
    status_byte[cmp_bit] = fsync.comparator_result;
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (haddr)
      tone_decode_status_ofs: next_rdata = {24'h000000, status_byte};
      decoder_power_select_ofs: next_rdata = {24'h000000, power_sel};
      power_clock_fsk_status_ofs: next_rdata = {24'h000000, pcfs};
      irq_status_ofs: next_rdata = {30'h0, irq_status};
      irq_enable_ofs: next_rdata = {30'h0, irq_enable};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata <= next_rdata;
    end
  end

  // ---------------- checks ----------------
  tone_latch_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (tone_event && fsync.receiver_output_enable) |=>
      tone_code == $past(fsync.tone_code))
    else $error("tone code not latched");
  code_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !tone_event |=> $stable(tone_code))
    else $error("tone code changed without event");
  tone_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (tone_event && irq_enable[irq_tone_bit]) |-> ##2 irq)
    else $error("tone interrupt missing");
  power_map_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(tone_rx_power && fsk_power))
    else $error("both front ends powered");
  reroute_a: assert property (@(posedge hclk) disable iff (!hresetn)
    port6_reroute == tone_rx_power)
    else $error("port reroute mismatch");
  fsk_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fsync.carrier_absent |=> pcfs[fsk_bit])
    else $error("fsk bit not forced high");
  carrier_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 pcfs[cd_bit] == $past(fsync.carrier_absent))
    else $error("carrier flag wrong");
  fsk_edge_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fsk_event |=> irq_status[irq_fsk_bit])
    else $error("fsk falling edge lost");
  one_per_rise_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tone_event |=> !tone_event)
    else $error("double tone event");
  steer_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fsync.tone_valid_steer |=> status_byte[steer_bit])
    else $error("steering flag not shown");
  fsk_raw_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !fsync.carrier_absent |=> pcfs[fsk_bit] == $past(fsync.fsk_raw))
    else $error("fsk raw data not passed");
  cmp_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && haddr == tone_decode_status_ofs) |=>
      hrdata[cmp_bit] == $past(fsync.comparator_result))
    else $error("comparator bit wrong");

  // start-up masking and tone code handling
  warm_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !warm_done |-> !tone_event && !fsk_event)
    else $error("edge seen before sync filled");
  no_code_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (tone_event && !fsync.receiver_output_enable) |=> $stable(tone_code))
    else $error("code taken with output disabled");
  steer_fall_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !fsync.tone_valid_steer |=> !status_byte[steer_bit])
    else $error("steering flag stuck high");
  code_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && haddr == tone_decode_status_ofs) |=>
      hrdata[3:0] == $past(tone_code))
    else $error("tone code read wrong");

  // interrupt flags and the level output
  tone_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tone_event |=> irq_status[irq_tone_bit])
    else $error("tone flag not set");
  tone_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (clear_bits[irq_tone_bit] && !tone_event) |=>
      !irq_status[irq_tone_bit])
    else $error("tone flag not cleared");
  irq_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (|(irq_status & irq_enable)) |=> irq)
    else $error("interrupt not raised");
  irq_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(|(irq_status & irq_enable)) |=> !irq)
    else $error("interrupt without cause");
  irq_en_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_fire && ap_addr == irq_enable_ofs) |=>
      irq_enable == $past(hwdata[1:0]))
    else $error("enable write lost");

  // power selection
  pwr_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_fire && ap_addr == decoder_power_select_ofs) |=>
      power_sel[7:6] == $past(hwdata[7:6]))
    else $error("power select write lost");
  pwr_tone_a: assert property (@(posedge hclk) disable iff (!hresetn)
    power_sel[7:6] == pwr_tone |=> tone_rx_power && !fsk_power)
    else $error("tone receiver not powered");
  pwr_fsk_a: assert property (@(posedge hclk) disable iff (!hresetn)
    power_sel[7:6] == pwr_fsk |=> fsk_power && !tone_rx_power)
    else $error("fsk decoder not powered");
  pwr_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    power_sel[7:6] == pwr_off |=> !tone_rx_power && !fsk_power)
    else $error("front end powered when off");
  sel_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    power_sel[5:0] == 6'h00)
    else $error("unused select bits set");

  // fsk status read path and bus answer
  carrier_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && haddr == power_clock_fsk_status_ofs) |=>
      hrdata[cd_bit] == $past(pcfs[cd_bit]))
    else $error("carrier flag read wrong");
  fsk_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && haddr == power_clock_fsk_status_ofs) |=>
      hrdata[fsk_bit] == $past(pcfs[fsk_bit]))
    else $error("fsk bit read wrong");
  bus_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("bus answer not ready okay");
endmodule // caller_id_decoder_status_control
`default_nettype wire

/* File: bench/front_end_model.sv */
// behavioural tone receiver and fsk demodulator front end
`timescale 1ns/1ps
`default_nettype none
module front_end_model (
  input wire logic [3:0] key_idx,
  input wire logic tone_on,
  input wire logic mark,
  input wire logic carrier_ok,
  input wire logic cmp_above,
  input wire logic tone_rx_power,
  input wire logic fsk_power,
  output var cid_pkg::front_s front_in
);
  import cid_pkg::*;
  logic [3:0] code;
  // index 0..9 digits, 10 star, 11 hash, 12..14 a-c, 15 d
  assign code = (key_idx == 4'h0) ? 4'ha : (key_idx <= 4'h9) ? key_idx :
    (key_idx == 4'hf) ? 4'h0 : key_idx + 4'h1;
  // unpowered receiver: code is meaningless, so show a flipped value
  assign front_in = {tone_rx_power ? code : ~code,
    tone_rx_power & tone_on,
    tone_rx_power,
    mark,
    ~(fsk_power & carrier_ok),
    cmp_above};
endmodule // front_end_model
`default_nettype wire

/* File: bench/caller_id_decoder_status_control_tb.sv */
// testbench: caller-id status and control registers over ahb-lite
`timescale 1ns/1ps
`default_nettype none
module caller_id_decoder_status_control_tb;
  import cid_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic tone_rx_power, fsk_power, port6_reroute;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd_v;
  logic [3:0] key_idx;
  logic tone_on, mark, carrier_ok, cmp_above;
  front_s front_in;
  int num_errors = 0;
  int n_checks = 0;
  localparam logic [3:0] key_code [16] = '{4'ha, 4'h1, 4'h2, 4'h3, 4'h4,
    4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hb, 4'hc, 4'hd, 4'he, 4'hf, 4'h0};

  caller_id_decoder_status_control dut_u (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .front_in(front_in),
    .tone_rx_power(tone_rx_power), .fsk_power(fsk_power),
    .port6_reroute(port6_reroute), .irq(irq));
  front_end_model front_u (.key_idx(key_idx), .tone_on(tone_on),
    .mark(mark), .carrier_ok(carrier_ok), .cmp_above(cmp_above),
    .tone_rx_power(tone_rx_power), .fsk_power(fsk_power),
    .front_in(front_in));

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // called right after a rising edge; address phase, then data phase
  task automatic bus(input logic [7:0] a, input logic w,
    input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_v = hrdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(rd_v, exp);
  endtask

  // two sync flops plus edge detect and irq register
  task automatic settle;
    repeat (6) @(posedge hclk);
  endtask

  initial begin
    repeat (5000) @(posedge hclk);
    num_errors++;
    close_out;
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    key_idx = 4'h0;
    tone_on = 1'b0;
    mark = 1'b0;
    carrier_ok = 1'b0;
    cmp_above = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(decoder_power_select_ofs, 32'h0);
    rchk(irq_status_ofs, 32'h0);
    for (int i = 0; i < 3; i++) begin
      bus(decoder_power_select_ofs, 1'b1, 32'(i << 6));
      rchk(decoder_power_select_ofs, 32'(i << 6));
      chk({29'h0, tone_rx_power, fsk_power, port6_reroute},
        {29'h0, i == 2, i == 1, i == 2});
    end
    bus(irq_clear_ofs, 1'b1, 32'h3); // main clock already runs
    for (int k = 0; k < 16; k++) begin
      key_idx <= 4'(k);
      tone_on <= 1'b1;
      settle;
      rchk(tone_decode_status_ofs, {24'h0, 4'h4, key_code[k]});
      rchk(irq_status_ofs, 32'h1);
      chk({31'h0, irq}, {31'h0, k != 0});
      if (k == 0) begin
        bus(irq_enable_ofs, 1'b1, 32'h1);
        settle;
        chk({31'h0, irq}, 32'h1);
      end
      bus(irq_clear_ofs, 1'b1, 32'h1);
      settle;
      rchk(irq_status_ofs, 32'h0);
      chk({31'h0, irq}, 32'h0);
      key_idx <= ~4'(k);
      tone_on <= 1'b0;
      settle;
      rchk(tone_decode_status_ofs, {28'h0, key_code[k]});
    end
    bus(decoder_power_select_ofs, 1'b1, 32'h40);
    settle;
    rchk(power_clock_fsk_status_ofs, 32'h6);
    carrier_ok <= 1'b1;
    mark <= 1'b1;
    cmp_above <= 1'b1;
    settle;
    rchk(power_clock_fsk_status_ofs, 32'h4);
    bus(tone_decode_status_ofs, 1'b0, 32'h0);
    chk(rd_v & 32'h80, 32'h80);
    bus(irq_clear_ofs, 1'b1, 32'h3);
    bus(irq_enable_ofs, 1'b1, 32'h2);
    mark <= 1'b0;
    settle;
    rchk(power_clock_fsk_status_ofs, 32'h0);
    rchk(irq_status_ofs, 32'h2);
    chk({31'h0, irq}, 32'h1);
    carrier_ok <= 1'b0;
    settle;
    rchk(power_clock_fsk_status_ofs, 32'h6);
    bus(8'h20, 1'b1, 32'hff);
    rchk(8'h20, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    close_out;
  end
endmodule // caller_id_decoder_status_control_tb
`default_nettype wire
